//--- rtl/soft_power_pkg.sv
// constants and carrier types for the soft power and wake control block
`default_nettype none
package soft_power_pkg;
    // configuration register offsets
    localparam logic [7:0] OFS_WAKE_ENABLE_ONE = 8'hb0;
    localparam logic [7:0] OFS_WAKE_ENABLE_TWO = 8'hb1;
    localparam logic [7:0] OFS_WAKE_STATUS_ONE = 8'hb2;
    localparam logic [7:0] OFS_WAKE_STATUS_TWO = 8'hb3;
    localparam logic [7:0] OFS_SECOND_DELAY = 8'hb8;
    localparam logic [7:0] OFS_WATCHDOG_POWER = 8'hf4;
    // run-time acpi/pme/smi registers (block-local offsets)
    localparam logic [7:0] OFS_PM1_STATUS = 8'h00;
    localparam logic [7:0] OFS_PM1_ENABLE = 8'h02;
    localparam logic [7:0] OFS_ACPI_CONTROL = 8'h04;
    localparam logic [7:0] OFS_GPE_ENABLE = 8'h06;
    localparam logic [7:0] OFS_PME_ENABLE = 8'h08;
    localparam logic [7:0] OFS_SMI_ENABLE_TWO = 8'h0a;
    localparam logic [7:0] OFS_IRQ_MUX = 8'h0c;
    // field positions
    localparam int BIT_OFF_ENABLE = 0;
    localparam int BIT_FORCE_OFF = 4;
    localparam int BIT_FORCE_ON = 6;
    localparam int BIT_SOFTWARE_POWER_OFF = 7;
    localparam int BIT_RESTART_COUNT = 6;
    localparam int BIT_STOP_COUNT = 5;
    localparam int BIT_BUTTON_STS = 0;
    localparam int BIT_OVERRIDE_STS = 1;
    localparam int BIT_ACPI_ROUTE = 0;
    localparam int BIT_GPE_ROUTE = 0;
    localparam int BIT_DEVICE_IRQ_WAKE = 0;
    localparam int BIT_SMI_TO_PME = 0;
    localparam int BIT_LEGACY_ROUTE = 7;
    localparam int BIT_MUX_ON_PIN = 0;
    localparam int BIT_MUX_ACTIVE_HIGH = 1;
    localparam int BIT_MUX_PUSH_PULL = 2;
    // wake source index in the 16-bit enable/status pair
    localparam int WAKE_COUNT = 12;
    localparam int WS_BUTTON = 10;
    localparam int WS_STANDBY_POR = 11;
    // reset values
    localparam logic [7:0] RST_WAKE_ENABLE_ONE = 8'h00;
    localparam logic [7:0] RST_WAKE_ENABLE_TWO = 8'h01;
    localparam logic [7:0] RST_SECOND_DELAY = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // timing
    localparam int REF_CLK_HZ = 40_000_000;
    localparam int SLOW_CLK_HZ = 32_768;
    localparam int SLOW_DIV = REF_CLK_HZ / SLOW_CLK_HZ;
    localparam int DEBOUNCE_SLOW_TICKS = 8;
    localparam int DELAY_STEP_MS = 500;
    localparam int OVERRIDE_TICK_MS = 500;
    localparam int OVERRIDE_MIN_MS = 4000;
    localparam int OVERRIDE_TICKS = (OVERRIDE_MIN_MS + OVERRIDE_TICK_MS - 1) / OVERRIDE_TICK_MS;
    localparam int TICK_SLOW = SLOW_CLK_HZ * OVERRIDE_TICK_MS / 1000;
    // wake pins, raw (active low where the pin is)
    typedef struct packed {
        logic ring_one_n;
        logic ring_two_n;
        logic kbd_clk;
        logic mouse_clk;
        logic group_irq_one;
        logic group_irq_two;
        logic ir_rx_two;
        logic uart_rx_one;
        logic uart_rx_two;
        logic ring_n;
    } wake_pins_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    typedef struct packed {
        logic sci_pin_oe;
        logic sci_pin_out;
        logic sci_irq;
        logic smi;
    } event_out_s;
endpackage
`default_nettype wire

//--- rtl/soft_power_wake_control.sv
// soft power manager: wake sources, button off and override, sci/smi routing
//
// Contract
// - falling edge on button or enabled wake source drives power request low
// - wake sources are rings, kbd/mouse clocks, group irqs, ir, uart rx, button, por
// - force-on bit makes a standby reset turn power on
// - force-off bit makes a standby reset leave the request floating
// - a debounced button press turns power off while button-off enable is set
// - button-off enable resets to one
// - writing software power off bit turns power off
// - control bits 7..5 are software off, restart count, stop count
// - enables at b0 and b1, status at b2 and b3
// - status sets on every event, only enabled events and the button power on
// - second delay spans 500 ms to 128 s, resets to 500 ms
// - configuration registers except wake status reset only by battery reset
// - power state flip-flop survives on battery
// - override timer counts while button high, clears on release, 0.5 s steps
// - override fires after 4 to 4.5 s held and clears the power state
// - enabled override sets its status, clears button status, powers off
// - override status clears on write of one, zero is ignored
// - acpi route sends events to sci, legacy route to smi, both allowed
// - sci goes to pin or parallel irq, polarity and drive from mux register
// - button has acpi status and enable raising sci
// - gpe route lets pme events raise sci; smi events also with two enables
// - acpi status clears by write one and standby reset
// - acpi status raises sci only while enabled; it raises smi whenever legacy route is set
`default_nettype none
module soft_power_wake_control
    import soft_power_pkg::*;
#(
    parameter int DEBOUNCE_TICKS = DEBOUNCE_SLOW_TICKS
) (
    // clock and resets
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic battery_rst,
    // register access
    input wire soft_power_pkg::reg_req_s cfg_req,
    input wire soft_power_pkg::reg_req_s acpi_req,
    output logic [7:0] cfg_rdata,
    output logic [7:0] acpi_rdata,
    // pins
    input wire logic button_in,
    input wire soft_power_pkg::wake_pins_s wake_pins,
    input wire logic smi_events,
    output logic power_on_request_n,
    output logic power_on_request_oe,
    output soft_power_pkg::event_out_s events,
    output logic restart_count,
    output logic stop_count,
    output logic [7:0] second_delay_ms_steps
);
    import soft_power_pkg::*;

    localparam int NSYNC = 11;

    ////////////////////////////////////////////////////////////////////////
    // battery domain state: reset only by battery_rst
    typedef struct packed {
        logic [7:0] en_one;
        logic [7:0] en_two;
        logic [7:0] delay;
        logic [7:0] wdt;
        logic power_on;
        logic override_en;
    } bat_s;

    // standby domain state: reset by rst (standby power-on)
    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] prev;
        logic [15:0] slow_div;
        logic slow_tick;
        logic [3:0] deb_cnt;
        logic btn_stable;
        logic [15:0] half_sec;
        logic [3:0] ovr_cnt;
        logic [15:0] wsts;
        logic [1:0] pm1_sts;
        logic [1:0] pm1_en;
        logic acpi_route;
        logic gpe_route;
        logic dev_wake;
        logic smi_pme;
        logic legacy_route;
        logic [2:0] mux;
        logic por_pending;
        logic [7:0] cfg_rdata;
        logic [7:0] acpi_rdata;
        event_out_s ev;
        logic req_n;
        logic req_oe;
    } sb_s;

    bat_s b_q, b_d;
    sb_s s_q, s_d;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] fall;
    logic [WAKE_COUNT-1:0] wake_evt;
    logic [15:0] en_all;
    logic btn_press, override_fire, pwr_off, pwr_on_evt, sci_src, sci_level;

    assign raw = {button_in, wake_pins};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        b_d = b_q;
        en_all = {b_q.en_two, b_q.en_one};
        // two flops before any edge logic
        s_d.s1 = raw;
        s_d.s2 = s_q.s1;
        s_d.prev = s_q.s2;
        fall = s_q.prev & ~s_q.s2;
        // slow clock derived from ref_clk
        s_d.slow_tick = 1'b0;
        if (s_q.slow_div == 16'(SLOW_DIV - 1)) begin
            s_d.slow_div = 16'h0000;
            s_d.slow_tick = 1'b1;
        end else begin
            s_d.slow_div = s_q.slow_div + 16'h0001;
        end
        // button debounce on slow ticks
        btn_press = 1'b0;
        if (s_q.s2[NSYNC-1] == s_q.btn_stable) begin
            s_d.deb_cnt = 4'h0;
        end else if (s_q.slow_tick) begin
            if (s_q.deb_cnt == 4'(DEBOUNCE_TICKS - 1)) begin
                s_d.deb_cnt = 4'h0;
                s_d.btn_stable = s_q.s2[NSYNC-1];
                btn_press = ~s_q.s2[NSYNC-1];
            end else begin
                s_d.deb_cnt = s_q.deb_cnt + 4'h1;
            end
        end
        // override timer, half-second ticks while button held high
        override_fire = 1'b0;
        if (!s_q.btn_stable) begin
            s_d.half_sec = 16'h0000;
            s_d.ovr_cnt = 4'h0;
        end else if (s_q.slow_tick) begin
            if (s_q.half_sec == 16'(TICK_SLOW - 1)) begin
                s_d.half_sec = 16'h0000;
                if (s_q.ovr_cnt != 4'hf) begin
                    s_d.ovr_cnt = s_q.ovr_cnt + 4'h1;
                end
                // fires once, between 4 and 4.5 s
                override_fire = (s_q.ovr_cnt == 4'(OVERRIDE_TICKS - 1));
            end else begin
                s_d.half_sec = s_q.half_sec + 16'h0001;
            end
        end
        // wake events, status sets whether enabled or not
        wake_evt = {s_q.por_pending, btn_press, fall[9:0]};
        s_d.por_pending = 1'b0;
        for (int i = 0; i < WAKE_COUNT; i++) begin
            if (wake_evt[i]) begin
                s_d.wsts[i] = 1'b1;
            end
        end
        // the button wakes with no enable bit, only the other sources need one
        pwr_on_evt = |(wake_evt & en_all[WAKE_COUNT-1:0]) | btn_press;
        // button and override power-off, each gated by its enable
        pwr_off = (btn_press & b_q.en_two[BIT_OFF_ENABLE] & b_q.power_on)
            | (override_fire & b_q.override_en);
        // acpi status: write one clears, hardware set wins
        if (acpi_req.wr && acpi_req.addr == OFS_PM1_STATUS) begin
            s_d.pm1_sts = s_q.pm1_sts & ~acpi_req.wdata[1:0];
        end
        if (btn_press) begin
            s_d.pm1_sts[BIT_BUTTON_STS] = 1'b1;
        end
        if (override_fire && b_q.override_en) begin
            s_d.pm1_sts[BIT_OVERRIDE_STS] = 1'b1;
            s_d.pm1_sts[BIT_BUTTON_STS] = 1'b0;
        end
        // software power off
        if (cfg_req.wr && cfg_req.addr == OFS_WATCHDOG_POWER
            && cfg_req.wdata[BIT_SOFTWARE_POWER_OFF]) begin
            pwr_off = 1'b1;
        end
        // power state flip-flop lives in the battery domain
        if (pwr_off) begin
            b_d.power_on = 1'b0;
        end else if (pwr_on_evt && !b_q.power_on) begin
            b_d.power_on = 1'b1;
        end
        if (s_q.por_pending) begin
            if (b_q.en_two[BIT_FORCE_ON]) begin
                b_d.power_on = 1'b1;
            end else if (b_q.en_two[BIT_FORCE_OFF]) begin
                b_d.power_on = 1'b0;
            end
        end
        // request active low, floated when off so main power stays off
        s_d.req_n = ~b_d.power_on;
        s_d.req_oe = b_d.power_on;
        // configuration writes
        if (cfg_req.wr) begin
            case (cfg_req.addr)
                OFS_WAKE_ENABLE_ONE: b_d.en_one = cfg_req.wdata;
                OFS_WAKE_ENABLE_TWO: b_d.en_two = cfg_req.wdata;
                OFS_SECOND_DELAY: b_d.delay = cfg_req.wdata;
                OFS_WATCHDOG_POWER: b_d.wdt = {1'b0, cfg_req.wdata[6:0]};
                OFS_WAKE_STATUS_ONE: s_d.wsts[7:0] = s_d.wsts[7:0] & ~cfg_req.wdata;
                OFS_WAKE_STATUS_TWO: s_d.wsts[15:8] = s_d.wsts[15:8] & ~cfg_req.wdata;
                default: ;
            endcase
            // wake status keeps events that land in the clearing cycle
            for (int i = 0; i < WAKE_COUNT; i++) begin
                if (wake_evt[i]) begin
                    s_d.wsts[i] = 1'b1;
                end
            end
        end
        s_d.cfg_rdata = 8'h00;
        if (cfg_req.rd) begin
            case (cfg_req.addr)
                OFS_WAKE_ENABLE_ONE: s_d.cfg_rdata = b_q.en_one;
                OFS_WAKE_ENABLE_TWO: s_d.cfg_rdata = b_q.en_two;
                OFS_WAKE_STATUS_ONE: s_d.cfg_rdata = s_q.wsts[7:0];
                OFS_WAKE_STATUS_TWO: s_d.cfg_rdata = s_q.wsts[15:8];
                OFS_SECOND_DELAY: s_d.cfg_rdata = b_q.delay;
                OFS_WATCHDOG_POWER: s_d.cfg_rdata = b_q.wdt;
                default: s_d.cfg_rdata = 8'h00;
            endcase
        end
        // acpi run-time register writes
        if (acpi_req.wr) begin
            case (acpi_req.addr)
                OFS_PM1_ENABLE: begin
                    s_d.pm1_en = acpi_req.wdata[1:0];
                    b_d.override_en = acpi_req.wdata[BIT_OVERRIDE_STS];
                end
                OFS_ACPI_CONTROL: s_d.acpi_route = acpi_req.wdata[BIT_ACPI_ROUTE];
                OFS_GPE_ENABLE: s_d.gpe_route = acpi_req.wdata[BIT_GPE_ROUTE];
                OFS_PME_ENABLE: s_d.dev_wake = acpi_req.wdata[BIT_DEVICE_IRQ_WAKE];
                OFS_SMI_ENABLE_TWO: begin
                    s_d.smi_pme = acpi_req.wdata[BIT_SMI_TO_PME];
                    s_d.legacy_route = acpi_req.wdata[BIT_LEGACY_ROUTE];
                end
                OFS_IRQ_MUX: s_d.mux = acpi_req.wdata[2:0];
                default: ;
            endcase
        end
        s_d.acpi_rdata = 8'h00;
        if (acpi_req.rd) begin
            case (acpi_req.addr)
                OFS_PM1_STATUS: s_d.acpi_rdata = {6'h00, s_q.pm1_sts};
                OFS_PM1_ENABLE: s_d.acpi_rdata = {6'h00, s_q.pm1_en};
                OFS_ACPI_CONTROL: s_d.acpi_rdata = {7'h00, s_q.acpi_route};
                OFS_GPE_ENABLE: s_d.acpi_rdata = {7'h00, s_q.gpe_route};
                OFS_PME_ENABLE: s_d.acpi_rdata = {7'h00, s_q.dev_wake};
                OFS_SMI_ENABLE_TWO: s_d.acpi_rdata = {s_q.legacy_route, 6'h00, s_q.smi_pme};
                OFS_IRQ_MUX: s_d.acpi_rdata = {5'h00, s_q.mux};
                default: s_d.acpi_rdata = 8'h00;
            endcase
        end
        // event routing
        sci_src = |(s_q.pm1_sts & s_q.pm1_en)
            | (s_q.gpe_route & |(s_q.wsts[WAKE_COUNT-1:0] & en_all[WAKE_COUNT-1:0]))
            | (s_q.dev_wake & s_q.smi_pme & smi_events);
        sci_level = s_q.acpi_route & sci_src;
        s_d.ev.smi = s_q.legacy_route & (smi_events | (|s_q.pm1_sts));
        // pin vs parallel irq, polarity, drive type
        s_d.ev.sci_irq = ~s_q.mux[BIT_MUX_ON_PIN] & sci_level;
        s_d.ev.sci_pin_out = s_q.mux[BIT_MUX_ACTIVE_HIGH] ? sci_level : ~sci_level;
        // open drain drives only while the pin is to sit low
        s_d.ev.sci_pin_oe = s_q.mux[BIT_MUX_ON_PIN]
            & (s_q.mux[BIT_MUX_PUSH_PULL] | (s_q.mux[BIT_MUX_ACTIVE_HIGH] ^ sci_level));
    end

    ////////////////////////////////////////////////////////////////////////
    // battery-backed state; power_on reset value is off
    always_ff @(posedge ref_clk or posedge battery_rst) begin
        if (battery_rst) begin
            b_q <= '{en_one: RST_WAKE_ENABLE_ONE, en_two: RST_WAKE_ENABLE_TWO,
                     delay: RST_SECOND_DELAY, wdt: RST_ZERO, power_on: 1'b0,
                     override_en: 1'b0};
        end else begin
            b_q <= b_d;
        end
    end

    // standby state; a standby reset leaves a pending por event
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            // idle levels: button low, wake pins high, so no false edge
            s_q.s1 <= {1'b0, {(NSYNC-1){1'b1}}};
            s_q.s2 <= {1'b0, {(NSYNC-1){1'b1}}};
            s_q.prev <= {1'b0, {(NSYNC-1){1'b1}}};
            s_q.req_n <= 1'b1;
            s_q.ev.sci_pin_out <= 1'b1;
            s_q.por_pending <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata = s_q.cfg_rdata;
    assign acpi_rdata = s_q.acpi_rdata;
    assign power_on_request_n = s_q.req_n;
    assign power_on_request_oe = s_q.req_oe;
    assign events = s_q.ev;
    assign restart_count = b_q.wdt[BIT_RESTART_COUNT];
    assign stop_count = b_q.wdt[BIT_STOP_COUNT];
    assign second_delay_ms_steps = b_q.delay;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || battery_rst);

    power_off_sw_a: assert property (cfg_req.wr && cfg_req.addr == OFS_WATCHDOG_POWER
        && cfg_req.wdata[7] |=> !b_q.power_on ##1 !power_on_request_oe)
        else $error("software power off ignored");
    wake_on_a: assert property (!b_q.power_on && !pwr_off && !s_q.por_pending
        && |(fall[9:0] & en_all[9:0]) |=> b_q.power_on ##1 !power_on_request_n)
        else $error("enabled wake edge did not request power");
    status_set_a: assert property (fall[0] |=> s_q.wsts[0])
        else $error("wake status not set");
    override_clr_a: assert property (override_fire && b_q.override_en
        |=> s_q.pm1_sts[1] && !s_q.pm1_sts[0] && !b_q.power_on)
        else $error("override effects missing");
    override_time_a: assert property (override_fire |-> s_q.ovr_cnt == 4'd7)
        else $error("override fired at wrong count");
    timer_clear_a: assert property (!s_q.btn_stable |=> s_q.ovr_cnt == 4'h0)
        else $error("override timer not cleared");
    sts_zero_a: assert property (acpi_req.wr && acpi_req.addr == OFS_PM1_STATUS
        && acpi_req.wdata[1:0] == 2'b00 && s_q.pm1_sts[1] |=> s_q.pm1_sts[1])
        else $error("zero write cleared status");
    sci_gate_a: assert property (!s_q.acpi_route ##1 !s_q.acpi_route
        |-> !s_q.ev.sci_irq)
        else $error("sci without route enable");
    button_off_a: assert property (btn_press && !b_q.en_two[0] && !override_fire
        && !(cfg_req.wr && cfg_req.addr == OFS_WATCHDOG_POWER) && b_q.power_on
        |=> b_q.power_on)
        else $error("button turned power off while disabled");

    pwr_cycle_c: cover property (b_q.power_on ##[1:20] !b_q.power_on);
    override_c: cover property (override_fire && b_q.override_en);
    sci_c: cover property (s_q.ev.sci_irq);
endmodule
`default_nettype wire

//--- test/main_supply_model.sv
// main supply model: follows the power request pin with its pull-up
`default_nettype none
module main_supply_model (
    // request pin as the design drives it
    input wire logic power_on_request_n,
    input wire logic power_on_request_oe,
    // resolved pin and supply state
    output logic pin_level,
    output logic supply_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // a floated pin is pulled up, which the supply reads as off
    assign pin_level = power_on_request_oe ? power_on_request_n : 1'b1;
    assign supply_on = !pin_level;
endmodule
`default_nettype wire

//--- test/tb_soft_power_wake_control.sv
// self-checking bench for the soft power and wake control block
`default_nettype none
module tb_soft_power_wake_control;
    timeunit 1ns;
    timeprecision 1ps;
    import soft_power_pkg::*;
    localparam int DEB = 2;
    localparam int LIMIT = 90000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic battery_rst = 1'b1;
    reg_req_s cfg_req = '0;
    reg_req_s acpi_req = '0;
    logic [7:0] cfg_rdata, acpi_rdata, rd_v, second_delay_ms_steps;
    logic button_in = 1'b0;
    logic smi_events = 1'b0;
    wake_pins_s wake_pins = '1;
    logic power_on_request_n, power_on_request_oe, restart_count, stop_count;
    logic pin_level, supply_on;
    event_out_s events;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////
    soft_power_wake_control #(.DEBOUNCE_TICKS(DEB)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .battery_rst(battery_rst),
        .cfg_req(cfg_req), .acpi_req(acpi_req),
        .cfg_rdata(cfg_rdata), .acpi_rdata(acpi_rdata),
        .button_in(button_in), .wake_pins(wake_pins), .smi_events(smi_events),
        .power_on_request_n(power_on_request_n),
        .power_on_request_oe(power_on_request_oe),
        .events(events), .restart_count(restart_count), .stop_count(stop_count),
        .second_delay_ms_steps(second_delay_ms_steps)
    );
    main_supply_model supply_u (
        .power_on_request_n(power_on_request_n),
        .power_on_request_oe(power_on_request_oe),
        .pin_level(pin_level), .supply_on(supply_on)
    );
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("ERROR timeout expected finish seen hang");
            end_of_test();
        end
    end
    // one-cycle strobe; both buses answer on the cycle after the taking edge
    task automatic bus(input bit acpi, input bit wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        if (acpi) acpi_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
        else cfg_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        acpi_req = '0;
        cfg_req = '0;
        rd_v = acpi ? acpi_rdata : cfg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_power(input logic exp_on);
        int n;
        n = 0;
        while (supply_on !== exp_on && n < 12 * DEB * SLOW_DIV) begin
            cyc(1);
            n++;
        end
        check("supply_on", {7'h0, supply_on}, {7'h0, exp_on});
    endtask
    // press then release; the falling edge of the debounced level acts
    task automatic press();
        button_in = 1'b1;
        cyc(4 * DEB * SLOW_DIV);
        button_in = 1'b0;
    endtask
    task automatic standby_reset();
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        rst = 1'b0;
        battery_rst = 1'b0;
        cyc(3);
        // reset values and unmapped place
        bus(0, 0, OFS_WAKE_ENABLE_ONE, 8'h00); check("enable_one", rd_v, 8'h00);
        bus(0, 0, OFS_WAKE_ENABLE_TWO, 8'h00); check("enable_two", rd_v, 8'h01);
        bus(0, 0, OFS_SECOND_DELAY, 8'h00); check("second_delay", rd_v, 8'h00);
        check("delay_out", second_delay_ms_steps, 8'h00);
        bus(0, 0, OFS_WAKE_STATUS_TWO, 8'h00); check("status_two", rd_v, 8'h08);
        bus(0, 1, 8'h55, 8'hff);
        bus(0, 0, 8'h55, 8'h00); check("unmapped", rd_v, 8'h00);
        check("oe_after_reset", {7'h0, power_on_request_oe}, 8'h00);
        $display("test reset values done");
        // disabled wake event only sets status
        wake_pins.ring_n = 1'b0;
        cyc(10);
        check("disabled_wake", {7'h0, supply_on}, 8'h00);
        bus(0, 0, OFS_WAKE_STATUS_ONE, 8'h00); check("status_one", rd_v, 8'h01);
        bus(0, 1, OFS_WAKE_STATUS_ONE, 8'h01);
        bus(0, 0, OFS_WAKE_STATUS_ONE, 8'h00); check("status_clr", rd_v, 8'h00);
        bus(0, 1, OFS_WAKE_ENABLE_ONE, 8'h01);
        wake_pins.ring_n = 1'b1;
        cyc(6);
        wake_pins.ring_n = 1'b0;
        wait_power(1'b1);
        check("pin_low", {7'h0, pin_level}, 8'h00);
        wake_pins.ring_n = 1'b1;
        $display("test wake source done");
        // software off with the two counter bits
        bus(0, 1, OFS_WATCHDOG_POWER, 8'he0);
        wait_power(1'b0);
        bus(0, 0, OFS_WATCHDOG_POWER, 8'h00); check("watchdog_power_control", rd_v & 8'he0, 8'h60);
        check("count_bits", {6'h0, restart_count, stop_count}, 8'h03);
        bus(0, 1, OFS_WATCHDOG_POWER, 8'h00);
        $display("test software off done");
        // button turns on, raises sci, then turns off
        bus(1, 1, OFS_PM1_ENABLE, 8'h01);
        bus(1, 1, OFS_ACPI_CONTROL, 8'h01);
        press();
        wait_power(1'b1);
        bus(0, 0, OFS_WAKE_STATUS_TWO, 8'h00); check("button_sts", rd_v & 8'h04, 8'h04);
        cyc(4);
        check("sci_irq_set", {7'h0, events.sci_irq}, 8'h01);
        bus(1, 1, OFS_PM1_STATUS, 8'h00);
        bus(1, 0, OFS_PM1_STATUS, 8'h00); check("pm1_w0", rd_v & 8'h01, 8'h01);
        bus(1, 1, OFS_PM1_STATUS, 8'h01);
        cyc(3);
        check("sci_irq_clr", {7'h0, events.sci_irq}, 8'h00);
        bus(1, 1, OFS_PM1_ENABLE, 8'h00);
        press();
        wait_power(1'b0);
        bus(1, 0, OFS_PM1_STATUS, 8'h00); check("pm1_sts", rd_v & 8'h01, 8'h01);
        check("sci_masked", {7'h0, events.sci_irq}, 8'h00);
        $display("test button done");
        // force bits on a standby reset, never both together
        bus(0, 1, OFS_WAKE_ENABLE_TWO, 8'h41);
        standby_reset();
        wait_power(1'b1);
        bus(0, 0, OFS_WAKE_ENABLE_TWO, 8'h00); check("retained", rd_v, 8'h41);
        bus(0, 1, OFS_WAKE_ENABLE_TWO, 8'h11);
        standby_reset();
        wait_power(1'b0);
        check("floated", {7'h0, power_on_request_oe}, 8'h00);
        $display("test force bits done");
        // sci on the pin, open drain active low, fed by smi events
        bus(1, 1, OFS_SMI_ENABLE_TWO, 8'h81);
        bus(1, 0, OFS_SMI_ENABLE_TWO, 8'h00); check("smi_en_two", rd_v, 8'h81);
        bus(1, 1, OFS_PME_ENABLE, 8'h01);
        bus(1, 1, OFS_ACPI_CONTROL, 8'h01);
        bus(1, 1, OFS_IRQ_MUX, 8'h01);
        smi_events = 1'b1;
        cyc(3);
        check("smi_out", {7'h0, events.smi}, 8'h01);
        check("sci_pin_on", {6'h0, events.sci_pin_oe, events.sci_pin_out}, 8'h02);
        check("sci_irq_pin", {7'h0, events.sci_irq}, 8'h00);
        smi_events = 1'b0;
        cyc(3);
        check("sci_pin_idle", {6'h0, events.sci_pin_oe, events.sci_pin_out}, 8'h01);
        check("smi_idle", {7'h0, events.smi}, 8'h00);
        // enabled wake status reaches sci through the gpe route
        bus(1, 1, OFS_GPE_ENABLE, 8'h01);
        wake_pins.ring_n = 1'b0;
        wait_power(1'b1);
        cyc(2);
        check("gpe_sci", {7'h0, events.sci_pin_oe}, 8'h01);
        bus(0, 1, OFS_SECOND_DELAY, 8'h3f);
        bus(0, 0, OFS_SECOND_DELAY, 8'h00); check("delay_rw", rd_v, 8'h3f);
        check("delay_steps", second_delay_ms_steps, 8'h3f);
        $display("test event routing done");
        end_of_test();
    end
endmodule
`default_nettype wire
